// ### verilog/brx_pkg.sv
`default_nettype none
package brx_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ      = 200;
  localparam int STAB_TIME_MS = 30;
  // Longest wait, rounded down to whole cycles
  localparam int STAB_CYCLES  = STAB_TIME_MS * 1000 * CLK_MHZ;
  localparam int STAB_W       = 23;
  localparam int SEL_W        = 2;
  localparam int DIV_W        = 3;
  localparam int CNT_W        = 4;

  // ==========================================================
  // Status word field positions
  localparam int STAT_GLOBAL_EN = 7;
  localparam int STAT_Z         = 6;
  localparam int STAT_CARRY     = 0;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    OP_NO_OPERATION, OP_CARRY_SET, OP_CARRY_CLR, OP_ZERO_SET, OP_ZERO_CLR,
    OP_BIT_ONE, OP_BIT_ZERO, OP_LOOP_B, OP_LOOP_C, OP_LOOP_MEM,
    OP_INT_EN, OP_INT_DIS, OP_HALT, OP_STOP
  } brx_op_t;

  typedef enum logic [1:0] {SRC_SADDR, SRC_SFR, SRC_ACC, SRC_STATUS} brx_src_t;
  typedef enum logic [1:0] {WB_NONE, WB_REG_B, WB_REG_C, WB_MEM} brx_wb_t;
  typedef enum logic [2:0] {ST_OSC_WAIT, ST_IDLE, ST_EXEC, ST_HALT, ST_STOP} brx_state_t;

  typedef struct packed {
    brx_op_t    op;
    brx_src_t   src;
    logic [2:0] bit_sel;
    logic [7:0] disp;
  } brx_instr_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  program_status_word;
    logic [7:0]  acc;
    logic [7:0]  reg_b;
    logic [7:0]  reg_c;
    logic [7:0]  mem;
  } brx_operand_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  program_status_word;
    brx_wb_t     wb;
    logic [7:0]  wb_data;
  } brx_result_t;

  // ==========================================================
  // Functions
  function automatic logic [2:0] instr_len(brx_op_t op, brx_src_t src);
    case (op)
      OP_CARRY_SET, OP_CARRY_CLR, OP_ZERO_SET, OP_ZERO_CLR,
      OP_LOOP_B, OP_LOOP_C:          instr_len = 3'h2;
      OP_BIT_ONE, OP_BIT_ZERO:       instr_len = (src == SRC_ACC) ? 3'h3 : 3'h4;
      OP_LOOP_MEM, OP_INT_EN, OP_INT_DIS: instr_len = 3'h3;
      default:                       instr_len = 3'h1;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] instr_clocks(brx_op_t op, brx_src_t src);
    case (op)
      OP_CARRY_SET, OP_CARRY_CLR, OP_ZERO_SET, OP_ZERO_CLR,
      OP_LOOP_B, OP_LOOP_C, OP_INT_EN, OP_INT_DIS: instr_clocks = 4'h6;
      OP_BIT_ONE, OP_BIT_ZERO:      instr_clocks = (src == SRC_ACC) ? 4'h8 : 4'ha;
      OP_LOOP_MEM:                  instr_clocks = 4'h8;
      default:                      instr_clocks = 4'h2;
    endcase
  endfunction

  function automatic logic [15:0] sext(logic [7:0] d);
    sext = {{8{d[7]}}, d};
  endfunction

  // Divider terminal count: divide by 1, 2, 4 or 8
  function automatic logic [DIV_W-1:0] div_last(logic [SEL_W-1:0] sel);
    div_last = DIV_W'((4'h1 << sel) - 4'h1);
  endfunction

endpackage
`default_nettype wire

// ### verilog/brx_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module brx_clk_div
  import brx_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;

  // ==========================================================
  // One-cycle enable per CPU clock; counter cleared to zero while stopped
  assign tick = run && (cnt >= div_last(sel));

  always_comb begin
    next_cnt = cnt;
    if (tick || !run) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule // brx_clk_div
`default_nettype wire

// ### verilog/brx_osc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module brx_osc_timer
  import brx_pkg::*;
#(
  parameter int CYCLES = STAB_CYCLES
)(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      stable
);

  localparam logic [STAB_W-1:0] LOAD = STAB_W'(CYCLES - 1);

  logic [STAB_W-1:0] cnt;
  logic [STAB_W-1:0] next_cnt;

  // ==========================================================
  // Counts from reset release, and again from each restart
  assign stable = (cnt == '0);

  always_comb begin
    next_cnt = cnt;
    if (start) begin
      next_cnt = LOAD;
    end else if (!stable) begin
      next_cnt = cnt - 23'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= LOAD;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule // brx_osc_timer
`default_nettype wire

// ### verilog/brx_exec.sv
// Functional notes
// - Flag branches: 2 bytes, 6 clocks, relative
// - Bit-one on saddr/sfr: 4 bytes, 10 clocks
// - Bit-one on accumulator: 3 bytes, 8 clocks
// - Bit-one on status word: 4 bytes, 10
// - Bit-zero forms mirror bit-one, branch on 0
// - Register loop: decrement, branch if nonzero
// - Memory loop: decrement, write back, branch
// - Interrupt enable sets global enable flag
// - Interrupt disable clears global enable flag
// - Each counted clock is one CPU clock
// - Wait oscillator stabilization after reset/stop
`timescale 1ns/1ps
`default_nettype none
module brx_exec
  import brx_pkg::*;
#(
  parameter int STAB_CYCLES_P = STAB_CYCLES
)(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [SEL_W-1:0] cpu_clk_sel,
  input  wire logic             wake_pin,
  input  wire logic             instr_valid,
  input  wire brx_instr_t       instr,
  input  wire brx_operand_t     opnd,
  output logic                  instr_ready,
  output logic                  done,
  output brx_result_t           result,
  output logic                  cpu_halted,
  output logic                  osc_stopped
);

  brx_state_t       state;
  brx_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  brx_op_t          op_q;
  brx_op_t          next_op;
  brx_result_t      res;
  brx_result_t      next_res;
  logic             next_done;
  logic             done_q;
  logic             tick;
  logic             osc_stable;
  logic             osc_start;
  logic             fire;
  logic             wake_meta;
  logic             wake_sync;
  logic             bit_val;
  logic             taken;
  logic [2:0]       len;
  logic [7:0]       dec;
  brx_result_t      calc;
  logic [15:0]      pc_disp;

  // ==========================================================
  // Wake pin crosses in from outside
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
    end
  end

  // ==========================================================
  // CPU clock enable; frozen in both standby modes
  brx_clk_div u_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .run     (state == ST_IDLE || state == ST_EXEC),
    .sel     (cpu_clk_sel),
    .tick    (tick)
  );

  // Restarted when stop is released
  assign osc_start = (state == ST_STOP) && wake_sync;

  brx_osc_timer #(.CYCLES(STAB_CYCLES_P)) u_osc (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (osc_start),
    .stable  (osc_stable)
  );

  // ==========================================================
  // Handshake: one instruction per CPU clock edge when idle
  assign instr_ready = (state == ST_IDLE) && tick;
  assign fire        = instr_valid && instr_ready;
  assign cpu_halted  = (state == ST_HALT);
  assign osc_stopped = (state == ST_STOP);
  assign done        = done_q;
  assign result      = res;
  assign pc_disp     = opnd.pc + sext(instr.disp);

  // ==========================================================
  // Decode and condition; operands are sampled at issue
  always_comb begin
    bit_val = 1'b0;
    taken   = 1'b0;
    dec     = 8'h00;
    len     = instr_len(instr.op, instr.src);
    calc    = '{pc: 16'h0000, program_status_word: opnd.program_status_word, wb: WB_NONE, wb_data: 8'h00};
    case (instr.src)
      SRC_SADDR, SRC_SFR: bit_val = opnd.mem[instr.bit_sel];
      SRC_ACC:            bit_val = opnd.acc[instr.bit_sel];
      SRC_STATUS:         bit_val = opnd.program_status_word[instr.bit_sel];
      default:            bit_val = 1'b0;
    endcase
    case (instr.op)
      OP_CARRY_SET: taken = opnd.program_status_word[STAT_CARRY];
      OP_CARRY_CLR: taken = !opnd.program_status_word[STAT_CARRY];
      OP_ZERO_SET:  taken = opnd.program_status_word[STAT_Z];
      OP_ZERO_CLR:  taken = !opnd.program_status_word[STAT_Z];
      OP_BIT_ONE:   taken = bit_val;
      OP_BIT_ZERO:  taken = !bit_val;
      OP_LOOP_B: begin
        dec     = opnd.reg_b - 8'h01;
        calc.wb = WB_REG_B;
        taken   = (dec != 8'h00);
      end
      OP_LOOP_C: begin
        dec     = opnd.reg_c - 8'h01;
        calc.wb = WB_REG_C;
        taken   = (dec != 8'h00);
      end
      OP_LOOP_MEM: begin
        dec     = opnd.mem - 8'h01;
        calc.wb = WB_MEM;
        taken   = (dec != 8'h00);
      end
      OP_INT_EN:  calc.program_status_word[STAT_GLOBAL_EN] = 1'b1;
      OP_INT_DIS: calc.program_status_word[STAT_GLOBAL_EN] = 1'b0;
      default:    taken = 1'b0;
    endcase
    calc.wb_data = dec;
    // Untaken path falls through and leaves the flags alone
    if (taken) begin
      calc.pc = pc_disp + 16'(len);
    end else begin
      calc.pc = opnd.pc + 16'(len);
    end
  end

  // ==========================================================
  // Sequencer: counts CPU clocks, then enters standby if asked
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_op    = op_q;
    next_res   = res;
    next_done  = 1'b0;
    case (state)
      ST_OSC_WAIT: begin
        if (osc_stable) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (fire) begin
          next_res   = calc;
          next_op    = instr.op;
          next_cnt   = instr_clocks(instr.op, instr.src) - 4'h1;
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (tick) begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_done = 1'b1;
            if (op_q == OP_HALT) begin
              next_state = ST_HALT;
            end else if (op_q == OP_STOP) begin
              next_state = ST_STOP;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
      end
      ST_HALT: begin
        if (wake_sync) begin
          next_state = ST_IDLE;
        end
      end
      ST_STOP: begin
        if (wake_sync) begin
          next_state = ST_OSC_WAIT;
        end
      end
      default: next_state = ST_OSC_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state  <= ST_OSC_WAIT;
      cnt    <= '0;
      op_q   <= OP_NO_OPERATION;
      res    <= '0;
      done_q <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      op_q   <= next_op;
      res    <= next_res;
      done_q <= next_done;
    end
  end

  // ==========================================================
  // Checking helpers: CPU clocks seen since issue
  logic [CNT_W-1:0] ticks_seen;
  logic [CNT_W-1:0] clocks_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ticks_seen <= '0;
      clocks_q   <= '0;
    end else if (fire) begin
      ticks_seen <= '0;
      clocks_q   <= instr_clocks(instr.op, instr.src);
    end else if (state == ST_EXEC && tick) begin
      ticks_seen <= ticks_seen + 4'h1;
    end
  end

  // ==========================================================
  // Assertions
  flag_branch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_CARRY_SET && opnd.program_status_word[STAT_CARRY]
      |=> result.pc == $past(pc_disp) + 16'h0002)
    else $error("carry branch target wrong");

  bit_mem_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_BIT_ONE && instr.src == SRC_SFR && bit_val
      |=> result.pc == $past(pc_disp) + 16'h0004)
    else $error("sfr bit branch target wrong");

  bit_acc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_BIT_ONE && instr.src == SRC_ACC && bit_val
      |=> result.pc == $past(pc_disp) + 16'h0003)
    else $error("accumulator bit branch target wrong");

  bit_status_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_BIT_ONE && instr.src == SRC_STATUS && bit_val
      |=> result.pc == $past(pc_disp) + 16'h0004)
    else $error("status bit branch target wrong");

  bit_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_BIT_ZERO && instr.src == SRC_ACC && !bit_val
      |=> result.pc == $past(pc_disp) + 16'h0003 && clocks_q == 4'h8)
    else $error("bit zero branch wrong");

  loop_reg_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_LOOP_B
      |=> result.wb == WB_REG_B && result.wb_data == $past(opnd.reg_b) - 8'h01)
    else $error("register loop decrement wrong");

  loop_mem_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_LOOP_MEM && opnd.mem == 8'h01
      |=> result.wb == WB_MEM && result.pc == $past(opnd.pc) + 16'h0003)
    else $error("memory loop exit wrong");

  int_en_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_INT_EN |=> result.program_status_word[STAT_GLOBAL_EN] && clocks_q == 4'h6)
    else $error("enable flag not set");

  int_dis_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_INT_DIS |=> !result.program_status_word[STAT_GLOBAL_EN])
    else $error("enable flag not cleared");

  clock_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done |-> ticks_seen == clocks_q - 4'h1)
    else $error("instruction clock count wrong");

  osc_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    osc_start |=> !instr_ready [*8])
    else $error("issue during oscillator wait");

  untaken_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_ZERO_SET && !opnd.program_status_word[STAT_Z]
      |=> result.pc == $past(opnd.pc) + 16'h0002 && result.program_status_word == $past(opnd.program_status_word))
    else $error("untaken branch wrong");

  standby_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done && op_q == OP_STOP |-> osc_stopped && clocks_q == 4'h2)
    else $error("stop entry wrong");

  halt_entry_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    done && op_q == OP_HALT |-> cpu_halted && clocks_q == 4'h2)
    else $error("halt entry wrong");

  bit_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fire && instr.op == OP_BIT_ZERO && instr.src == SRC_SADDR && bit_val
      |=> result.pc == $past(opnd.pc) + 16'h0004 && clocks_q == 4'ha)
    else $error("bit zero fall through wrong");

endmodule // brx_exec
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import brx_pkg::*;

  // ==========================================================
  // Settle time shortened so the oscillator waits stay brief
  localparam int STAB = 20;

  logic             ref_clk;
  logic             reset_n;
  logic [SEL_W-1:0] cpu_clk_sel;
  logic             wake_pin;
  logic             instr_valid;
  brx_instr_t       instr;
  brx_operand_t     opnd;
  logic             instr_ready;
  logic             done;
  brx_result_t      result;
  logic             cpu_halted;
  logic             osc_stopped;
  int               failures;
  int               checks;

  brx_exec #(.STAB_CYCLES_P(STAB)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .cpu_clk_sel(cpu_clk_sel),
    .wake_pin(wake_pin), .instr_valid(instr_valid), .instr(instr), .opnd(opnd),
    .instr_ready(instr_ready), .done(done), .result(result),
    .cpu_halted(cpu_halted), .osc_stopped(osc_stopped)
  );

  // ==========================================================
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Whole run is under a thousand cycles, so 200 us means a hang
  initial begin
    #200000;
    failures++;
    results();
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic int exp_len(brx_op_t op, brx_src_t src);
    case (op)
      OP_CARRY_SET, OP_CARRY_CLR, OP_ZERO_SET, OP_ZERO_CLR, OP_LOOP_B, OP_LOOP_C: return 2;
      OP_BIT_ONE, OP_BIT_ZERO: return (src == SRC_ACC) ? 3 : 4;
      OP_LOOP_MEM, OP_INT_EN, OP_INT_DIS: return 3;
      default: return 1;
    endcase
  endfunction

  function automatic int exp_clk(brx_op_t op, brx_src_t src);
    case (op)
      OP_CARRY_SET, OP_CARRY_CLR, OP_ZERO_SET, OP_ZERO_CLR,
      OP_LOOP_B, OP_LOOP_C, OP_INT_EN, OP_INT_DIS: return 6;
      OP_BIT_ONE, OP_BIT_ZERO: return (src == SRC_ACC) ? 8 : 10;
      OP_LOOP_MEM: return 8;
      default: return 2;
    endcase
  endfunction

  // One instruction: offer, hold until taken, time it, judge the result
  task automatic run(input brx_op_t op, input brx_src_t src, input logic [2:0] bs,
                     input logic [7:0] disp, input brx_operand_t o, input logic taken,
                     input brx_wb_t ewb, input logic [7:0] ewd, input logic [7:0] epsw);
    int          n;
    int          d;
    logic        bad;
    logic [15:0] epc;
    d = 1 << cpu_clk_sel;
    epc = o.pc + 16'(exp_len(op, src)) + (taken ? {{8{disp[7]}}, disp} : 16'h0000);
    instr = '{op, src, bs, disp};
    opnd = o;
    instr_valid = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 200);
    chk("instruction taken", 1, instr_ready);
    @(posedge ref_clk);
    #1 instr_valid = 1'b0;
    n = 0;
    bad = 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
      if (instr_ready !== 1'b0 && done !== 1'b1)
        bad = 1'b1;
    end while (done !== 1'b1 && n < 200);
    chk("clock count", 32'((exp_clk(op, src) - 1) * d + 1), 32'(n));
    chk("ready while busy", 0, bad);
    chk("next pc", epc, result.pc);
    chk("status word", epsw, result.program_status_word);
    chk("write back", ewb, result.wb);
    if (ewb != WB_NONE)
      chk("write data", ewd, result.wb_data);
    @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    int n;
    reset_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("idle in reset", 0, {instr_ready, done, cpu_halted, osc_stopped, |result});
    reset_n = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 100);
    chk("settle after reset", 1, 32'(n >= STAB && n <= STAB + 4));
    @(posedge ref_clk);
    #1;
  endtask

  // Carry in bit 0 and zero in bit 6 set apart, so a swapped flag shows
  task automatic t_flag();
    brx_operand_t o;
    logic [7:0]   v;
    o = '0;
    o.pc = 16'h1000;
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h40 : 8'h01;
      o.program_status_word = v;
      run(OP_CARRY_SET, SRC_SADDR, 3'h0, 8'h80, o, v[0], WB_NONE, 8'h00, v);
      run(OP_CARRY_CLR, SRC_SADDR, 3'h0, 8'h7f, o, !v[0], WB_NONE, 8'h00, v);
      run(OP_ZERO_SET, SRC_SADDR, 3'h0, 8'hfe, o, v[6], WB_NONE, 8'h00, v);
      run(OP_ZERO_CLR, SRC_SADDR, 3'h0, 8'h05, o, !v[6], WB_NONE, 8'h00, v);
    end
  endtask

  // Selected source holds the pattern, the others its inverse
  task automatic t_bits();
    brx_operand_t o;
    logic [7:0]   pat;
    brx_src_t     s;
    for (int si = 0; si < 4; si++) begin
      for (int b = 0; b < 8; b += 7) begin
        for (int v = 0; v < 2; v++) begin
          s = brx_src_t'(si[1:0]);
          pat = v ? (8'h01 << b) : ~(8'h01 << b);
          o = '0;
          o.pc = 16'hfffe;
          o.mem = ~pat;
          o.acc = ~pat;
          o.program_status_word = ~pat;
          if (s == SRC_ACC)
            o.acc = pat;
          else if (s == SRC_STATUS)
            o.program_status_word = pat;
          else
            o.mem = pat;
          run(OP_BIT_ONE, s, b[2:0], 8'hf0, o, v == 1, WB_NONE, 8'h00, o.program_status_word);
          run(OP_BIT_ZERO, s, b[2:0], 8'h10, o, v == 0, WB_NONE, 8'h00, o.program_status_word);
        end
      end
    end
  endtask

  // Counts of 1 end the loop, counts of 0 wrap to ff and branch
  task automatic t_loops();
    brx_operand_t o;
    brx_op_t      lops [3] = '{OP_LOOP_B, OP_LOOP_C, OP_LOOP_MEM};
    logic [7:0]   iv;
    for (int k = 0; k < 6; k++) begin
      iv = (k % 2) ? 8'h00 : 8'h01;
      o = '{16'h2000, 8'hc1, 8'h00, 8'h55, 8'h55, 8'h55};
      if (k / 2 == 0)
        o.reg_b = iv;
      else if (k / 2 == 1)
        o.reg_c = iv;
      else
        o.mem = iv;
      run(lops[k / 2], SRC_SADDR, 3'h0, 8'h80, o, iv != 8'h01, brx_wb_t'(k / 2 + 1), iv - 8'h01, 8'hc1);
    end
  endtask

  task automatic t_misc();
    brx_operand_t o;
    o = '0;
    o.pc = 16'h3000;
    o.program_status_word = 8'h41;
    run(OP_INT_EN, SRC_SADDR, 3'h0, 8'h00, o, 1'b0, WB_NONE, 8'h00, 8'hc1);
    o.program_status_word = 8'hff;
    run(OP_INT_DIS, SRC_SADDR, 3'h0, 8'h00, o, 1'b0, WB_NONE, 8'h00, 8'h7f);
    run(OP_NO_OPERATION, SRC_SADDR, 3'h0, 8'h00, o, 1'b0, WB_NONE, 8'h00, 8'hff);
  endtask

  // Every counted clock stretches with the CPU clock divider
  task automatic t_div();
    brx_operand_t o;
    o = '0;
    o.program_status_word = 8'h01;
    o.acc = 8'h08;
    for (int s = 1; s < 4; s++) begin
      cpu_clk_sel = SEL_W'(s);
      run(OP_CARRY_SET, SRC_SADDR, 3'h0, 8'h20, o, 1'b1, WB_NONE, 8'h00, 8'h01);
      run(OP_BIT_ONE, SRC_ACC, 3'h3, 8'h20, o, 1'b1, WB_NONE, 8'h00, 8'h01);
    end
    cpu_clk_sel = '0;
  endtask

  task automatic t_standby();
    brx_operand_t o;
    int           n;
    logic         bad;
    o = '0;
    o.pc = 16'h4000;
    run(OP_HALT, SRC_SADDR, 3'h0, 8'h00, o, 1'b0, WB_NONE, 8'h00, 8'h00);
    chk("halted", 1, cpu_halted);
    instr_valid = 1'b1;
    bad = 1'b0;
    repeat (10) begin
      @(negedge ref_clk);
      bad = bad | (instr_ready !== 1'b0);
    end
    chk("ready while halted", 0, bad);
    // Drop the offer first, or the held halt is taken again on release
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    wake_pin = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cpu_halted !== 1'b0 && n < 20);
    chk("halt release", 1, 32'(n >= 2 && n <= 4));
    @(posedge ref_clk);
    #1;
    wake_pin = 1'b0;
    instr_valid = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    run(OP_STOP, SRC_SADDR, 3'h0, 8'h00, o, 1'b0, WB_NONE, 8'h00, 8'h00);
    chk("oscillator stopped", 1, osc_stopped);
    wake_pin = 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 100);
    chk("settle after stop", 1, 32'(n >= STAB && n <= STAB + 6));
    chk("oscillator running", 0, osc_stopped);
    @(posedge ref_clk);
    #1;
    wake_pin = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    failures = 0;
    checks = 0;
    reset_n = 1'b0;
    cpu_clk_sel = '0;
    wake_pin = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    opnd = '0;
    t_reset();
    t_flag();
    t_bits();
    t_loops();
    t_misc();
    t_div();
    t_standby();
    t_reset();
    t_flag();
    results();
  end

endmodule // tb
`default_nettype wire
